// ### verilog/azdt_defines.svh
// Register offsets, field positions, reset values and threshold codes for the angle trim block.
`ifndef AZDT_DEFINES_SVH
`define AZDT_DEFINES_SVH
// ======================================================================
// Register indices
`define AZDT_REG_ZERO_LO      5'h00
`define AZDT_REG_ZERO_HI      5'h01
`define AZDT_REG_TRIM_AMT     5'h02
`define AZDT_REG_TRIM_EN      5'h03
`define AZDT_REG_FIELD_THR    5'h06
`define AZDT_REG_DIRECTION    5'h09
`define AZDT_REG_FIELD_STAT   5'h1B
// ======================================================================
// Field positions
`define AZDT_BIT_TRIM_X       0
`define AZDT_BIT_TRIM_Y       1
`define AZDT_BIT_DIRECTION    7
`define AZDT_BIT_FIELD_HIGH   7
`define AZDT_BIT_FIELD_LOW    6
`define AZDT_THR_LOW_MSB      7
`define AZDT_THR_LOW_LSB      5
`define AZDT_THR_HIGH_MSB     4
`define AZDT_THR_HIGH_LSB     2
// ======================================================================
// Reset values
`define AZDT_RST_ZERO_LO      8'h00
`define AZDT_RST_ZERO_HI      8'h00
`define AZDT_RST_TRIM_AMT     8'h00
`define AZDT_RST_TRIM_EN      2'h0
`define AZDT_RST_DIRECTION    1'h0
`define AZDT_RST_LOW_THR      3'h0
`define AZDT_RST_HIGH_THR     3'h7
`define AZDT_RST_LOW_FLAG     1'h1
`define AZDT_RST_HIGH_FLAG    1'h0
// ======================================================================
// Field threshold ladder in mT, rising level; falling level is 6 mT lower.
`define AZDT_FIELD_HYST_MT    8'h06
`define AZDT_THR_BASE_MT      8'h1A
`define AZDT_THR_STEP_MT      8'h0E
`endif

// ### verilog/azdt_pkg.sv
// Types shared by the angle trim block.
`default_nettype none
package azdt_pkg;
   typedef logic [15:0] azdt_angle_t;
   typedef logic [7:0]  azdt_byte_t;
   typedef logic [2:0]  azdt_thr_code_t;
endpackage
`default_nettype wire

// ### verilog/azdt_core.sv
// Zero offset, direction, bias trim and field flag logic of the angle sensor.
// ======================================================================
// Summary of operation
// - The zero position is held as a 16-bit value, one part in 65536 of a turn.
// - The output angle is the raw angle minus the zero position.
// - The stored zero_offset resets to 0 and is the complement of the zero position.
// - The zero position is 65536 minus zero_offset, so 0 means no offset.
// - Register 0 holds the low byte of zero_offset and register 1 the high byte.
// - By default the angle increases for clockwise field rotation seen from the top.
// - direction_select 0 makes clockwise positive and 1 makes counterclockwise positive.
// - bias_trim_amount is an unsigned 8-bit value from 0 to 255 setting the bias reduction.
// - Two trim-enable bits choose which Hall axis receives the bias reduction.
// - trim_x_enable disables X-axis trimming at 0 and enables it at 1.
// - trim_y_enable disables Y-axis trimming at 0 and enables it at 1.
// - With both enables set the reduction is equal on both axes.
// - field_low_flag or field_high_flag rises when the field lies outside the threshold range.
// - Register 27 shows field_high_flag at bit 7 and field_low_flag at bit 6; high drives a pin.
// - Thresholds are 3-bit codes in register 6 and the flags use about 6 mT hysteresis.
// ======================================================================
`timescale 1ns/10ps
`default_nettype none
`include "azdt_defines.svh"

module azdt_core (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        reg_wr_en,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output var  logic [7:0]  reg_rdata,
   input  wire logic [15:0] raw_angle,
   input  wire logic [7:0]  field_mt,
   output var  logic [15:0] angle_out,
   output var  logic [7:0]  trim_x_amount,
   output var  logic [7:0]  trim_y_amount,
   output var  logic        field_low_flag,
   output var  logic        field_high_flag
);

   // ======================================================================
   // Configuration registers
   azdt_pkg::azdt_byte_t     zero_lo_r, zero_lo_nxt;
   azdt_pkg::azdt_byte_t     zero_hi_r, zero_hi_nxt;
   azdt_pkg::azdt_byte_t     trim_amt_r, trim_amt_nxt;
   logic                     trim_x_en_r, trim_x_en_nxt;
   logic                     trim_y_en_r, trim_y_en_nxt;
   logic                     dir_sel_r, dir_sel_nxt;
   azdt_pkg::azdt_thr_code_t low_thr_r, low_thr_nxt;
   azdt_pkg::azdt_thr_code_t high_thr_r, high_thr_nxt;

   always_comb begin
      zero_lo_nxt   = zero_lo_r;
      zero_hi_nxt   = zero_hi_r;
      trim_amt_nxt  = trim_amt_r;
      trim_x_en_nxt = trim_x_en_r;
      trim_y_en_nxt = trim_y_en_r;
      dir_sel_nxt   = dir_sel_r;
      low_thr_nxt   = low_thr_r;
      high_thr_nxt  = high_thr_r;
      if (reg_wr_en) begin
         unique case (reg_addr)
            `AZDT_REG_ZERO_LO: zero_lo_nxt = reg_wdata;
            `AZDT_REG_ZERO_HI: zero_hi_nxt = reg_wdata;
            `AZDT_REG_TRIM_AMT: trim_amt_nxt = reg_wdata;
            `AZDT_REG_TRIM_EN: begin
               trim_x_en_nxt = reg_wdata[`AZDT_BIT_TRIM_X];
               trim_y_en_nxt = reg_wdata[`AZDT_BIT_TRIM_Y];
            end
            `AZDT_REG_FIELD_THR: begin
               low_thr_nxt  = reg_wdata[`AZDT_THR_LOW_MSB:`AZDT_THR_LOW_LSB];
               high_thr_nxt = reg_wdata[`AZDT_THR_HIGH_MSB:`AZDT_THR_HIGH_LSB];
            end
            `AZDT_REG_DIRECTION: dir_sel_nxt = reg_wdata[`AZDT_BIT_DIRECTION];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         zero_lo_r   <= `AZDT_RST_ZERO_LO;
         zero_hi_r   <= `AZDT_RST_ZERO_HI;
         trim_amt_r  <= `AZDT_RST_TRIM_AMT;
         {trim_y_en_r, trim_x_en_r} <= `AZDT_RST_TRIM_EN;
         dir_sel_r   <= `AZDT_RST_DIRECTION;
         low_thr_r   <= `AZDT_RST_LOW_THR;
         high_thr_r  <= `AZDT_RST_HIGH_THR;
      end else begin
         zero_lo_r   <= zero_lo_nxt;
         zero_hi_r   <= zero_hi_nxt;
         trim_amt_r  <= trim_amt_nxt;
         trim_x_en_r <= trim_x_en_nxt;
         trim_y_en_r <= trim_y_en_nxt;
         dir_sel_r   <= dir_sel_nxt;
         low_thr_r   <= low_thr_nxt;
         high_thr_r  <= high_thr_nxt;
      end
   end

   // ======================================================================
   // Input synchronisers
   // The front end sits outside this clock, so both buses pass two stages.
   // A multi-bit word may be caught mid-change; the front end holds it steady.
   azdt_pkg::azdt_angle_t raw_s1_r, raw_s2_r;
   azdt_pkg::azdt_byte_t  fld_s1_r, fld_s2_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         raw_s1_r <= 16'h0000;
         raw_s2_r <= 16'h0000;
         fld_s1_r <= 8'h00;
         fld_s2_r <= 8'h00;
      end else begin
         raw_s1_r <= raw_angle;
         raw_s2_r <= raw_s1_r;
         fld_s1_r <= field_mt;
         fld_s2_r <= fld_s1_r;
      end
   end

   // ======================================================================
   // Angle path
   // Adding Z equals subtracting 65536 - Z once wrapped to 16 bits.
   azdt_pkg::azdt_angle_t zero_off;
   azdt_pkg::azdt_angle_t dir_angle;
   azdt_pkg::azdt_angle_t angle_nxt;
   azdt_pkg::azdt_angle_t angle_r;

   always_comb begin
      zero_off  = {zero_hi_r, zero_lo_r};
      dir_angle = dir_sel_r ? 16'(16'h0000 - raw_s2_r) : raw_s2_r;
      angle_nxt = 16'(dir_angle + zero_off);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         angle_r <= 16'h0000;
      end else begin
         angle_r <= angle_nxt;
      end
   end

   // ======================================================================
   // Bias trim per axis
   logic [7:0] trim_x_nxt, trim_y_nxt;
   logic [7:0] trim_x_r, trim_y_r;

   always_comb begin
      trim_x_nxt = trim_x_en_r ? trim_amt_r : 8'h00;
      trim_y_nxt = trim_y_en_r ? trim_amt_r : 8'h00;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         trim_x_r <= 8'h00;
         trim_y_r <= 8'h00;
      end else begin
         trim_x_r <= trim_x_nxt;
         trim_y_r <= trim_y_nxt;
      end
   end

   // ======================================================================
   // Field flags with hysteresis
   function automatic logic [7:0] azdt_rise_mt(input logic [2:0] code);
      azdt_rise_mt = 8'(`AZDT_THR_BASE_MT + 8'(code) * `AZDT_THR_STEP_MT);
   endfunction

   logic low_flag_r, low_flag_nxt;
   logic high_flag_r, high_flag_nxt;
   logic [7:0] low_rise, high_rise;

   always_comb begin
      low_rise      = azdt_rise_mt(low_thr_r);
      high_rise     = azdt_rise_mt(high_thr_r);
      low_flag_nxt  = low_flag_r;
      high_flag_nxt = high_flag_r;
      // Low flag sets below the falling level and clears at or above the rising one.
      if (fld_s2_r < 8'(low_rise - `AZDT_FIELD_HYST_MT)) begin
         low_flag_nxt = 1'b1;
      end else if (fld_s2_r >= low_rise) begin
         low_flag_nxt = 1'b0;
      end
      if (fld_s2_r >= high_rise) begin
         high_flag_nxt = 1'b1;
      end else if (fld_s2_r < 8'(high_rise - `AZDT_FIELD_HYST_MT)) begin
         high_flag_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         low_flag_r  <= `AZDT_RST_LOW_FLAG;
         high_flag_r <= `AZDT_RST_HIGH_FLAG;
      end else begin
         low_flag_r  <= low_flag_nxt;
         high_flag_r <= high_flag_nxt;
      end
   end

   // ======================================================================
   // Read port
   logic [7:0] rdata_nxt, rdata_r;

   always_comb begin
      rdata_nxt = 8'h00;
      unique case (reg_addr)
         `AZDT_REG_ZERO_LO:   rdata_nxt = zero_lo_r;
         `AZDT_REG_ZERO_HI:   rdata_nxt = zero_hi_r;
         `AZDT_REG_TRIM_AMT:  rdata_nxt = trim_amt_r;
         `AZDT_REG_TRIM_EN:   rdata_nxt = {6'h00, trim_y_en_r, trim_x_en_r};
         `AZDT_REG_FIELD_THR: rdata_nxt = {low_thr_r, high_thr_r, 2'h0};
         `AZDT_REG_DIRECTION: rdata_nxt = {dir_sel_r, 7'h00};
         `AZDT_REG_FIELD_STAT: begin
            rdata_nxt[`AZDT_BIT_FIELD_HIGH] = high_flag_r;
            rdata_nxt[`AZDT_BIT_FIELD_LOW]  = low_flag_r;
         end
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata       = rdata_r;
   assign angle_out       = angle_r;
   assign trim_x_amount   = trim_x_r;
   assign trim_y_amount   = trim_y_r;
   assign field_low_flag  = low_flag_r;
   assign field_high_flag = high_flag_r;

endmodule
`default_nettype wire

// ### tb/azdt_core_assertions.sv
// Port checker of the angle trim block.
`timescale 1ns/10ps
`default_nettype none
// ====================
// Checker
module azdt_core_checker (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        reg_wr_en,
   input wire logic [4:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic [15:0] raw_angle,
   input wire logic [7:0]  field_mt,
   input wire logic [15:0] angle_out,
   input wire logic [7:0]  trim_x_amount,
   input wire logic [7:0]  trim_y_amount,
   input wire logic        field_low_flag,
   input wire logic        field_high_flag
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence x_off_s;
      reg_wr_en && reg_addr == 5'h03 && !reg_wdata[0] ##1 !(reg_wr_en && reg_addr == 5'h03);
   endsequence
   sequence y_off_s;
      reg_wr_en && reg_addr == 5'h03 && !reg_wdata[1] ##1 !(reg_wr_en && reg_addr == 5'h03);
   endsequence
   sequence lo_wr_s;
      reg_wr_en && reg_addr == 5'h00 ##1 !reg_wr_en && reg_addr == 5'h00;
   endsequence
   a_trim_x_off: assert property (x_off_s |-> ##1 trim_x_amount == 8'h00)
      else $error("x trim not cleared");
   a_trim_y_off: assert property (y_off_s |-> ##1 trim_y_amount == 8'h00)
      else $error("y trim not cleared");
   a_trim_both_equal: assert property (trim_x_amount != 8'h00 && trim_y_amount != 8'h00
      |-> trim_x_amount == trim_y_amount) else $error("unequal trims");
   a_zero_readback: assert property (lo_wr_s |=> reg_rdata == $past(reg_wdata, 2))
      else $error("low offset byte lost");
   a_unmapped_zero: assert property (!(reg_addr inside {5'h00, 5'h01, 5'h02, 5'h03,
      5'h06, 5'h09, 5'h1B}) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_flag_status: assert property (reg_addr == 5'h1B |=> reg_rdata[7:6] ==
      {$past(field_high_flag), $past(field_low_flag)}) else $error("status bits wrong");
   a_angle_hold: assert property (($stable(raw_angle) && !reg_wr_en)[*5]
      |-> $stable(angle_out)) else $error("angle moved");
   a_field_high: assert property ((field_mt == 8'hFF)[*4] |-> field_high_flag)
      else $error("high flag missing");
   a_field_low: assert property ((field_mt == 8'h00)[*4]
      |-> field_low_flag && !field_high_flag) else $error("low flag missing");
endmodule
bind azdt_core azdt_core_checker u_chk (.mclk, .rst, .reg_wr_en, .reg_addr, .reg_wdata,
   .reg_rdata, .raw_angle, .field_mt, .angle_out, .trim_x_amount, .trim_y_amount,
   .field_low_flag, .field_high_flag);
`default_nettype wire

// ### tb/azdt_host.sv
// Host controller model driving the register port.
`timescale 1ns/10ps
`default_nettype none
// ====================
// Host
module azdt_host (
   input  wire logic       mclk,
   output var  logic       reg_wr_en,
   output var  logic [4:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr_en = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
   end
   // One strobe per byte, so a new zero position takes two writes.
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr_en = 1'b0;
      reg_wdata = ~d;
   endtask
   // Address is held two edges so either read latency reading gives the same data.
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ### tb/azdt_core_tb.sv
// Self-checking bench of the angle trim block.
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bench
module azdt_core_tb;
   logic        mclk, rst, reg_wr_en, field_low_flag, field_high_flag;
   logic [4:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, field_mt, trim_x_amount, trim_y_amount, rd_val;
   logic [15:0] raw_angle, angle_out;
   int          miscompares = 0;
   int          checks_done = 0;
   int          cycles = 0;
   azdt_core dut (.mclk, .rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .raw_angle,
      .field_mt, .angle_out, .trim_x_amount, .trim_y_amount, .field_low_flag, .field_high_flag);
   azdt_host host (.mclk, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         miscompares = miscompares + 1;
         report_and_stop();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Front-end inputs cross a two-flop synchroniser, so each change gets 4 cycles.
   task automatic front(input logic [15:0] a, input logic [7:0] f);
      @(negedge mclk);
      raw_angle = a;
      field_mt = f;
      repeat (4) @(negedge mclk);
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
      host.rd(a, rd_val);
      check({8'h00, rd_val}, {8'h00, exp});
   endtask
   initial begin
      rst = 1'b1;
      raw_angle = 16'h0000;
      field_mt = 8'h00;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      rdchk(5'h00, 8'h00);
      rdchk(5'h01, 8'h00);
      rdchk(5'h04, 8'h00);
      host.wr(5'h04, 8'hA5);
      rdchk(5'h04, 8'h00);
      rdchk(5'h06, 8'h1C);
      rdchk(5'h09, 8'h00);
      front(16'h1234, 8'h00);
      check(angle_out, 16'h1234);
      host.rd(5'h1B, rd_val);
      check({14'h0000, rd_val[7:6]}, 16'h0001);
      host.wr(5'h00, 8'hC7);
      host.wr(5'h01, 8'hF1);
      rdchk(5'h00, 8'hC7);
      rdchk(5'h01, 8'hF1);
      front(16'h1234, 8'hFF);
      check(angle_out, 16'h03FB);
      host.rd(5'h1B, rd_val);
      check({14'h0000, rd_val[7:6]}, 16'h0002);
      host.wr(5'h09, 8'h80);
      rdchk(5'h09, 8'h80);
      front(16'h1234, 8'h1E);
      check(angle_out, 16'hDF93);
      check({14'h0000, field_high_flag, field_low_flag}, 16'h0000);
      host.wr(5'h06, 8'h00);
      host.wr(5'h09, 8'h00);
      front(16'h0000, 8'h14);
      check(angle_out, 16'hF1C7);
      check({14'h0000, field_high_flag, field_low_flag}, 16'h0002);
      front(16'h0000, 8'h13);
      check({14'h0000, field_high_flag, field_low_flag}, 16'h0001);
      host.wr(5'h02, 8'hFF);
      rdchk(5'h02, 8'hFF);
      for (int e = 0; e < 4; e++) begin
         host.wr(5'h03, e[7:0]);
         repeat (3) @(negedge mclk);
         check({trim_y_amount, trim_x_amount}, {{8{e[1]}}, {8{e[0]}}});
         rdchk(5'h03, e[7:0]);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
